// ==== hdl/fp_error_break_event_signal.sv ====
// Shared floating-point error and pending break-event output pin logic
`timescale 1ns/1ps
module fp_error_break_event_signal (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic stop_clock_request_b,
  input  wire logic debug_probe_request_b,
  input  wire logic float_error_indication,
  input  wire logic break_event_pending,
  output logic      fp_error_break_event_out_b,
  output logic      pending_break_indication,
  output logic      stop_clock_active
);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: both request pins arrive from outside the clock domain

  localparam int unsigned PIN_COUNT = 2;
  // Depth of the synchroniser, used by the latency checks below
  localparam int SYNC_LAG = fp_break_pkg::SYNC_STAGES;

  logic [PIN_COUNT-1:0] pin_raw_b;
  logic [PIN_COUNT-1:0] pin_sync_b;
  logic                 stop_sync_b;
  logic                 probe_sync_b;

  // Bit 0 is stop-clock, bit 1 is the probe request
  assign pin_raw_b = {debug_probe_request_b, stop_clock_request_b};

  for (genvar i = 0; i < PIN_COUNT; i++) begin : g_sync
    pin_sync #(
      .RESET_LEVEL (fp_break_pkg::PIN_DEASSERTED)
    ) u_sync (
      .clk          (clk),
      .rst_b        (rst_b),
      .pin_in       (pin_raw_b[i]),
      .pin_sync_out (pin_sync_b[i])
    );
  end

  assign stop_sync_b  = pin_sync_b[0];
  assign probe_sync_b = pin_sync_b[1];

  logic stop_on;
  logic probe_on;
  logic break_src;

  assign stop_on   = (stop_sync_b == fp_break_pkg::PIN_ASSERTED);
  assign probe_on  = (probe_sync_b == fp_break_pkg::PIN_ASSERTED);
  // A probe during stop-clock is just another break source
  assign break_src = break_event_pending | probe_on;

  ////////////////////////////////////////////////////////////////////////
  // Break state: latches on a break and only leaves when stop-clock goes away

  // Break decode, shared by the pin and the flag so that they never disagree
  function automatic logic is_break(input fp_break_pkg::break_state_t s);
    return (s == fp_break_pkg::STOP_BREAK);
  endfunction

  fp_break_pkg::break_state_t state_q;
  fp_break_pkg::break_state_t state_d;

  always_comb begin
    state_d = state_q;
    case (state_q)
      fp_break_pkg::RUN_IDLE: begin
        if (stop_on) begin
          state_d = break_src ? fp_break_pkg::STOP_BREAK : fp_break_pkg::STOP_WAIT;
        end
      end
      fp_break_pkg::STOP_WAIT: begin
        if (!stop_on) begin
          state_d = fp_break_pkg::RUN_IDLE;
        end else if (break_src) begin
          state_d = fp_break_pkg::STOP_BREAK;
        end
      end
      fp_break_pkg::STOP_BREAK: begin
        // Sticky: the source may vanish, the pin must not
        if (!stop_on) begin
          state_d = fp_break_pkg::RUN_IDLE;
        end
      end
      default: state_d = fp_break_pkg::RUN_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= fp_break_pkg::RUN_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Shared pin: meaning follows stop-clock

  logic pin_d;
  logic pin_q;
  logic brk_q;
  logic stop_q;

  always_comb begin
    if (is_break(state_d)) begin
      pin_d = fp_break_pkg::PIN_ASSERTED;
    end else if (!stop_on && float_error_indication) begin
      pin_d = fp_break_pkg::PIN_ASSERTED;
    end else begin
      pin_d = fp_break_pkg::PIN_DEASSERTED;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_q  <= fp_break_pkg::PIN_RESET_LEVEL;
      brk_q  <= fp_break_pkg::BREAK_RESET_VALUE;
      stop_q <= 1'h0;
    end else begin
      pin_q  <= pin_d;
      brk_q  <= is_break(state_d);
      stop_q <= stop_on;
    end
  end

  // All three outputs come straight from flops, so the pin never glitches
  assign fp_error_break_event_out_b = pin_q;
  assign pending_break_indication   = brk_q;
  assign stop_clock_active          = stop_q;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  chk_break_holds: assert property (
    @(posedge clk) disable iff (!rst_b)
    (brk_q && stop_on) |=> (brk_q && pin_q == fp_break_pkg::PIN_ASSERTED)
  ) else $error("break indication dropped while stop-clock still active");

  chk_break_release: assert property (
    @(posedge clk) disable iff (!rst_b)
    (brk_q && !stop_on && !float_error_indication) |=> (!brk_q && pin_q == fp_break_pkg::PIN_DEASSERTED)
  ) else $error("break indication not released after stop-clock withdrawn");

  chk_float_error: assert property (
    @(posedge clk) disable iff (!rst_b)
    (!stop_on && float_error_indication) |=> (pin_q == fp_break_pkg::PIN_ASSERTED)
  ) else $error("float error not reported while running");

  chk_error_masked: assert property (
    @(posedge clk) disable iff (!rst_b)
    (stop_on && float_error_indication && !break_src && !brk_q) |=> (pin_q == fp_break_pkg::PIN_DEASSERTED)
  ) else $error("float error leaked onto pin during stop-clock");

  chk_break_pending: assert property (
    @(posedge clk) disable iff (!rst_b)
    (stop_on && break_event_pending) |=> (pin_q == fp_break_pkg::PIN_ASSERTED && brk_q)
  ) else $error("pending break not reported during stop-clock");

  chk_probe_break: assert property (
    @(posedge clk) disable iff (!rst_b)
    (stop_on && probe_on) |=> brk_q
  ) else $error("probe request during stop-clock not treated as break");

  chk_probe_running: assert property (
    @(posedge clk) disable iff (!rst_b)
    (!stop_on && $past(!stop_on)) |-> !brk_q
  ) else $error("break indicated while stop-clock inactive");

  chk_pin_idle: assert property (
    @(posedge clk) disable iff (!rst_b)
    (!stop_on && !float_error_indication) |=> (pin_q == fp_break_pkg::PIN_DEASSERTED)
  ) else $error("pin asserted with no cause");

  // Latency checks start once reset has been gone for a full synchroniser depth
  chk_stop_sync_lag: assert property (
    @(posedge clk) disable iff (!rst_b)
    $past(rst_b, SYNC_LAG) |->
      (stop_sync_b == $past(stop_clock_request_b, SYNC_LAG))
  ) else $error("stop-clock synchroniser latency or polarity wrong");

  chk_probe_sync_lag: assert property (
    @(posedge clk) disable iff (!rst_b)
    $past(rst_b, SYNC_LAG) |->
      (probe_sync_b == $past(debug_probe_request_b, SYNC_LAG))
  ) else $error("probe synchroniser latency or polarity wrong");

  chk_pin_has_cause: assert property (
    @(posedge clk) disable iff (!rst_b)
    (pin_q == fp_break_pkg::PIN_ASSERTED) |->
      (brk_q || $past(!stop_on && float_error_indication))
  ) else $error("pin asserted with neither a break nor a running error");

  chk_break_needs_stop: assert property (
    @(posedge clk) disable iff (!rst_b)
    brk_q |-> $past(stop_on)
  ) else $error("break indicated without stop-clock in the cycle before");

  chk_flag_matches_pin: assert property (
    @(posedge clk) disable iff (!rst_b)
    brk_q |-> (pin_q == fp_break_pkg::PIN_ASSERTED)
  ) else $error("break flag set while the pin is released");

  chk_probe_ignored: assert property (
    @(posedge clk) disable iff (!rst_b)
    (!stop_on && probe_on && !float_error_indication) |=> (!brk_q && pin_q == fp_break_pkg::PIN_DEASSERTED)
  ) else $error("probe request acted on while stop-clock inactive");

  chk_wait_no_break: assert property (
    @(posedge clk) disable iff (!rst_b)
    (stop_on && !break_src && !brk_q) |=> !brk_q
  ) else $error("break indicated during stop-clock with no source");

  chk_error_at_release: assert property (
    @(posedge clk) disable iff (!rst_b)
    (brk_q && !stop_on && float_error_indication) |=> (!brk_q && pin_q == fp_break_pkg::PIN_ASSERTED)
  ) else $error("float error lost when stop-clock withdrawn after a break");

endmodule

// ==== pkg/fp_break_pkg.sv ====
// Shared constants for the error and break-event pin logic
package fp_break_pkg;

  // Active-low pin levels
  localparam logic PIN_ASSERTED   = 1'h0;
  localparam logic PIN_DEASSERTED = 1'h1;

  // Reset values
  localparam logic PIN_RESET_LEVEL   = 1'h1;
  localparam logic BREAK_RESET_VALUE = 1'h0;

  // Synchroniser depth for pin inputs
  localparam int unsigned SYNC_STAGES = 2;

  typedef enum logic [1:0] {
    RUN_IDLE,
    STOP_WAIT,
    STOP_BREAK
  } break_state_t;

endpackage

// ==== hdl/pin_sync.sv ====
// Two-flop synchroniser for one asynchronous pin input
`timescale 1ns/1ps
module pin_sync #(
  parameter logic RESET_LEVEL = 1'h1
) (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic pin_in,
  output logic      pin_sync_out
);

  logic meta_q;
  logic sync_q;

  // The first stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= RESET_LEVEL;
      sync_q <= RESET_LEVEL;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
    end
  end

  assign pin_sync_out = sync_q;

endmodule

// ==== bench/core_logic_model.sv ====
// System core logic model that drives stop-clock and probe pins
`timescale 1ns/1ps
module core_logic_model (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic want_stop,
  input  wire logic want_probe,
  input  wire logic auto_release,
  input  wire logic pin_b,
  output logic      stop_clock_request_b,
  output logic      debug_probe_request_b
);
  logic served_q;
  // Once a break is seen, withdraw stop-clock until the user drops its request
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      served_q <= 1'h0;
    end else if (!want_stop) begin
      served_q <= 1'h0;
    end else if (auto_release && pin_b === 1'h0) begin
      served_q <= 1'h1;
    end
  end
  assign stop_clock_request_b  = ~(want_stop & ~served_q);
  assign debug_probe_request_b = ~want_probe;
endmodule

// ==== bench/fp_error_break_event_signal_test.sv ====
// Self-checking bench for the shared error and break-event pin
`timescale 1ns/1ps
module fp_error_break_event_signal_test;
  logic clk = 1'h0, rst_b = 1'h0, fe = 1'h0, bp = 1'h0;
  logic ws = 1'h0, wp = 1'h0, ar = 1'h0;
  logic stop_b, probe_b, out_b, pb, sca;
  int   n_errors = 0, n_tests = 0;
  always #2.5 clk = ~clk;
  core_logic_model u_core (.clk(clk), .rst_b(rst_b), .want_stop(ws), .want_probe(wp), .auto_release(ar),
    .pin_b(out_b), .stop_clock_request_b(stop_b), .debug_probe_request_b(probe_b));
  fp_error_break_event_signal u_dut (.clk(clk), .rst_b(rst_b), .stop_clock_request_b(stop_b),
    .debug_probe_request_b(probe_b), .float_error_indication(fe), .break_event_pending(bp),
    .fp_error_break_event_out_b(out_b), .pending_break_indication(pb), .stop_clock_active(sca));
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string what, input logic exp, input logic got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic conclude;
    $display("errors %0d comparisons %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic t_fp_error;
    fe = 1'h1; step(1);
    chk("out_b", fp_break_pkg::PIN_ASSERTED, out_b);
    chk("pb", 1'h0, pb);
    fe = 1'h0; step(1);
    chk("out_b", fp_break_pkg::PIN_DEASSERTED, out_b);
  endtask
  task automatic t_sticky_break;
    ws = 1'h1; step(3);
    chk("sca", 1'h1, sca);
    fe = 1'h1; step(1);
    chk("out_b", fp_break_pkg::PIN_DEASSERTED, out_b);
    fe = 1'h0; bp = 1'h1; step(1);
    chk("out_b", fp_break_pkg::PIN_ASSERTED, out_b);
    chk("pb", 1'h1, pb);
    bp = 1'h0; step(3);
    chk("out_b", fp_break_pkg::PIN_ASSERTED, out_b);
    ws = 1'h0; step(3);
    chk("out_b", fp_break_pkg::PIN_DEASSERTED, out_b);
    chk("sca", 1'h0, sca);
    chk("pb", 1'h0, pb);
  endtask
  task automatic t_auto_release;
    ar = 1'h1; ws = 1'h1; step(3);
    bp = 1'h1; step(1);
    bp = 1'h0;
    chk("out_b", fp_break_pkg::PIN_ASSERTED, out_b);
    step(4);
    chk("out_b", fp_break_pkg::PIN_DEASSERTED, out_b);
    ws = 1'h0; ar = 1'h0; step(3);
  endtask
  task automatic t_probe;
    ws = 1'h1; step(3);
    wp = 1'h1; step(3);
    chk("out_b", fp_break_pkg::PIN_ASSERTED, out_b);
    chk("pb", 1'h1, pb);
    wp = 1'h0; ws = 1'h0; step(3);
    wp = 1'h1; step(4);
    chk("out_b", fp_break_pkg::PIN_DEASSERTED, out_b);
    chk("pb", 1'h0, pb);
    wp = 1'h0; step(3);
  endtask
  task automatic t_release_error;
    ws = 1'h1; step(fp_break_pkg::SYNC_STAGES + 1);
    bp = 1'h1; step(1);
    bp = 1'h0; fe = 1'h1; step(1);
    chk("out_b", fp_break_pkg::PIN_ASSERTED, out_b);
    chk("pb", 1'h1, pb);
    ws = 1'h0; step(3);
    chk("out_b", fp_break_pkg::PIN_ASSERTED, out_b);
    chk("pb", 1'h0, pb);
    fe = 1'h0; step(1);
    chk("out_b", fp_break_pkg::PIN_DEASSERTED, out_b);
  endtask
  task automatic t_reset_mid;
    ws = 1'h1; step(3);
    bp = 1'h1; step(1);
    chk("out_b", fp_break_pkg::PIN_ASSERTED, out_b);
    bp = 1'h0; rst_b = 1'h0; step(2);
    chk("out_b", fp_break_pkg::PIN_RESET_LEVEL, out_b);
    chk("pb", 1'h0, pb);
    chk("sca", 1'h0, sca);
    rst_b = 1'h1; step(1);
    chk("out_b", fp_break_pkg::PIN_RESET_LEVEL, out_b);
    step(2);
    chk("sca", 1'h1, sca);
    chk("out_b", fp_break_pkg::PIN_DEASSERTED, out_b);
    ws = 1'h0; step(3);
  endtask
  initial begin
    step(5);
    rst_b = 1'h1;
    chk("out_b", fp_break_pkg::PIN_RESET_LEVEL, out_b);
    step(1);
    t_fp_error();
    t_sticky_break();
    t_auto_release();
    t_probe();
    t_release_error();
    t_reset_mid();
    conclude();
  end
  // Whole sequence takes about 70 cycles; 400 cycles leaves ample slack
  initial begin
    #2000;
    n_errors++;
    conclude();
  end
endmodule
